// ---- logic/rss_exec.sv ----
// Purpose: Four-phase execution of rotate, fill, sleep and subtract instructions
// Assumes: Register file read data is combinational on the read address
// Notes:   One mclk_i cycle per phase; sleep halts phasing until a wake
`timescale 1ns/1ps
`include "rss_defines.svh"

// Behaviour
// - Rotate right, bit0 to bit7, N Z
// - Destination bit selects accumulator or register
// - Access bit picks access bank or bank select
// - Indexed literal offset when a=0, extended, f<=5Fh
// - Fill writes FFh, no flag changes
// - Sleep entered in the final phase
// - Sleep clears powerdown, sets timeout, clears watchdog
// - Watchdog wake clears the timeout flag
// - Accumulator minus register minus inverted carry
// - Literal minus accumulator into accumulator
// - Register minus accumulator to chosen destination
module rss_exec
  import rss_pkg::*;
#(
  parameter int BANK_W = 4
)
(
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  // Instruction fetch
  input  wire logic [15:0]           instr_i,
  input  wire logic                  instr_valid_i,
  output logic                       instr_take_o,
  // Addressing controls
  input  wire logic [BANK_W-1:0]     bank_select_reg_i,
  input  wire logic                  ext_set_en_i,
  input  wire logic [BANK_W+7:0]     fsr2_i,
  // Register file
  output logic [BANK_W+7:0]          rd_addr_o,
  output logic                       rd_en_o,
  input  wire logic [7:0]            rd_data_i,
  output logic [BANK_W+7:0]          wr_addr_o,
  output logic                       wr_en_o,
  output logic [7:0]                 wr_data_o,
  // Core state
  output logic [7:0]                 w_o,
  output logic [4:0]                 status_o,
  // Power and watchdog
  output logic                       timeout_flag_o,
  output logic                       powerdown_flag_o,
  output logic                       sleep_o,
  output logic                       watchdog_clr_o,
  input  wire logic                  wake_i,
  input  wire logic                  watchdog_wake_i
);
  import rss_pkg::*;

  rss_phase_t        phase_r;
  rss_op_t           op_r;
  logic              dest_f_r;
  logic [BANK_W+7:0] f_addr_r;
  logic [7:0]        lit_r;
  logic [7:0]        opnd_r;
  logic [7:0]        result_r;
  logic [4:0]        flags_r;
  logic [7:0]        w_r;
  logic [4:0]        status_r;
  logic              timeout_flag_r;
  logic              powerdown_flag_r;
  logic              watchdog_clr_r;
  logic [7:0]        alu_res;
  logic              alu_n;
  logic              alu_ov;
  logic              alu_z;
  logic              alu_dc;
  logic              alu_c;
  logic              is_sub;

  function automatic rss_op_t rss_decode(input logic [15:0] ins);
    if ((ins & `RSS_SLEEP_MASK) == `RSS_SLEEP_VAL)
      rss_decode = RSS_OP_SLEEP;
    else if ((ins & `RSS_RRNC_MASK) == `RSS_RRNC_VAL)
      rss_decode = RSS_OP_RRNC;
    else if ((ins & `RSS_FILL_MASK) == `RSS_FILL_VAL)
      rss_decode = RSS_OP_FILL;
    else if ((ins & `RSS_SUBB_MASK) == `RSS_SUBB_VAL)
      rss_decode = RSS_OP_SUBB;
    else if ((ins & `RSS_SUBLIT_MASK) == `RSS_SUBLIT_VAL)
      rss_decode = RSS_OP_SUBLIT;
    else if ((ins & `RSS_SUBF_MASK) == `RSS_SUBF_VAL)
      rss_decode = RSS_OP_SUBF;
    else
      rss_decode = RSS_OP_NONE;
  endfunction

  // Data-memory address of the register operand
  function automatic logic [BANK_W+7:0] rss_faddr(input logic [15:0] ins);
    logic [7:0] f;
    f = ins[7:0];
    if (ins[`RSS_BIT_A])
      rss_faddr = {bank_select_reg_i, f};
    else if (ext_set_en_i && (f <= `RSS_ILO_MAX))
      rss_faddr = fsr2_i + {{BANK_W{1'b0}}, f};
    else if (f <= `RSS_ILO_MAX)
      rss_faddr = {{BANK_W{1'b0}}, f};
    else
      rss_faddr = {{BANK_W{1'b1}}, f};
  endfunction

  rss_alu u_alu (
    .op_i       (op_r),
    .file_val_i (opnd_r),
    .w_val_i    (w_r),
    .lit_i      (lit_r),
    .carry_i    (status_r[`RSS_ST_C]),
    .result_o   (alu_res),
    .n_o        (alu_n),
    .ov_o       (alu_ov),
    .z_o        (alu_z),
    .dc_o       (alu_dc),
    .c_o        (alu_c)
  );

  assign is_sub = (op_r == RSS_OP_SUBB) || (op_r == RSS_OP_SUBLIT) || (op_r == RSS_OP_SUBF);

  // Phase sequencer
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      phase_r <= RSS_PH_Q1;
    else
      case (phase_r)
        RSS_PH_Q1: phase_r <= RSS_PH_Q2;
        RSS_PH_Q2: phase_r <= RSS_PH_Q3;
        RSS_PH_Q3: phase_r <= RSS_PH_Q4;
        RSS_PH_Q4: phase_r <= (op_r == RSS_OP_SLEEP) ? RSS_PH_SLEEP : RSS_PH_Q1;
        RSS_PH_SLEEP: phase_r <= (wake_i || watchdog_wake_i) ? RSS_PH_Q1 : RSS_PH_SLEEP;
        default: phase_r <= RSS_PH_Q1;
      endcase
  end

  // Q1 decode
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      op_r     <= RSS_OP_NONE;
      dest_f_r <= 1'b0;
      f_addr_r <= '0;
      lit_r    <= 8'h00;
    end
    else if (phase_r == RSS_PH_Q1)
    begin
      op_r     <= instr_valid_i ? rss_decode(instr_i) : RSS_OP_NONE;
      dest_f_r <= instr_i[`RSS_BIT_D] || (rss_decode(instr_i) == RSS_OP_FILL);
      f_addr_r <= rss_faddr(instr_i);
      lit_r    <= instr_i[7:0];
    end
  end

  // Q2 operand read, Q3 process
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      opnd_r   <= 8'h00;
      result_r <= 8'h00;
      flags_r  <= 5'h00;
    end
    else if (phase_r == RSS_PH_Q2)
      opnd_r <= rd_data_i;
    else if (phase_r == RSS_PH_Q3)
    begin
      result_r <= alu_res;
      flags_r  <= {alu_n, alu_ov, alu_z, alu_dc, alu_c};
    end
  end

  // Q4 accumulator and status write-back
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      w_r      <= `RSS_W_RST;
      status_r <= `RSS_STATUS_RST;
    end
    else if (phase_r == RSS_PH_Q4)
    begin
      if (op_r == RSS_OP_SUBLIT || ((op_r == RSS_OP_RRNC || op_r == RSS_OP_SUBB ||
          op_r == RSS_OP_SUBF) && !dest_f_r))
        w_r <= result_r;
      if (op_r == RSS_OP_RRNC)
      begin
        status_r[`RSS_ST_N] <= flags_r[`RSS_ST_N];
        status_r[`RSS_ST_Z] <= flags_r[`RSS_ST_Z];
      end
      else if (is_sub)
        status_r <= flags_r;
    end
  end

  // Power-down and time-out flags, watchdog clear
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      timeout_flag_r   <= `RSS_TMO_RST;
      powerdown_flag_r <= `RSS_PWD_RST;
      watchdog_clr_r   <= 1'b0;
    end
    else
    begin
      watchdog_clr_r <= (phase_r == RSS_PH_Q4) && (op_r == RSS_OP_SLEEP);
      if ((phase_r == RSS_PH_Q4) && (op_r == RSS_OP_SLEEP))
      begin
        timeout_flag_r   <= 1'b1;
        powerdown_flag_r <= 1'b0;
      end
      else if ((phase_r == RSS_PH_SLEEP) && watchdog_wake_i)
        timeout_flag_r <= 1'b0;
    end
  end

  assign instr_take_o     = (phase_r == RSS_PH_Q1);
  assign rd_en_o          = (phase_r == RSS_PH_Q2) && (op_r == RSS_OP_RRNC ||
                            op_r == RSS_OP_FILL || op_r == RSS_OP_SUBB ||
                            op_r == RSS_OP_SUBF);
  assign rd_addr_o        = f_addr_r;
  assign wr_addr_o        = f_addr_r;
  assign wr_data_o        = result_r;
  assign wr_en_o          = (phase_r == RSS_PH_Q4) && dest_f_r && (op_r == RSS_OP_RRNC ||
                            op_r == RSS_OP_FILL || op_r == RSS_OP_SUBB ||
                            op_r == RSS_OP_SUBF);
  assign w_o              = w_r;
  assign status_o         = status_r;
  assign timeout_flag_o   = timeout_flag_r;
  assign powerdown_flag_o = powerdown_flag_r;
  assign sleep_o          = (phase_r == RSS_PH_SLEEP);
  assign watchdog_clr_o   = watchdog_clr_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_rotate_data: assert property (
    (phase_r == RSS_PH_Q2) && (op_r == RSS_OP_RRNC)
    |-> ##2 (wr_data_o == {$past(rd_data_i[0], 2), $past(rd_data_i[7:1], 2)}))
    else $error("rotate result wrong");
  a_dest_w: assert property (
    (phase_r == RSS_PH_Q4) && (op_r == RSS_OP_SUBF) && !dest_f_r
    |-> !wr_en_o ##1 (w_o == $past(result_r)))
    else $error("destination select wrong");
  a_bank_select: assert property (
    (phase_r == RSS_PH_Q1) && instr_valid_i && instr_i[`RSS_BIT_A]
    |=> (f_addr_r == {$past(bank_select_reg_i), $past(instr_i[7:0])}))
    else $error("bank select address wrong");
  a_indexed_mode: assert property (
    (phase_r == RSS_PH_Q1) && !instr_i[`RSS_BIT_A] && ext_set_en_i &&
    (instr_i[7:0] <= `RSS_ILO_MAX)
    |=> (f_addr_r == $past(fsr2_i) + {{BANK_W{1'b0}}, $past(instr_i[7:0])}))
    else $error("indexed address wrong");
  a_fill_ones: assert property (
    (phase_r == RSS_PH_Q4) && (op_r == RSS_OP_FILL)
    |-> wr_en_o && (wr_data_o == `RSS_ALL_ONES) ##1 $stable(status_o))
    else $error("fill ones wrong");
  a_sleep_entry: assert property (
    (phase_r == RSS_PH_Q1) && instr_valid_i && (instr_i == `RSS_SLEEP_VAL)
    |-> ##4 sleep_o)
    else $error("sleep not entered");
  a_sleep_flags: assert property (
    (phase_r == RSS_PH_Q4) && (op_r == RSS_OP_SLEEP)
    |=> timeout_flag_o && !powerdown_flag_o && watchdog_clr_o && $stable(status_o))
    else $error("sleep side effects wrong");
  a_wdt_wake: assert property (
    sleep_o && watchdog_wake_i |=> !timeout_flag_o && !sleep_o)
    else $error("watchdog wake flag wrong");
  a_borrow_sub: assert property (
    (phase_r == RSS_PH_Q4) && (op_r == RSS_OP_SUBB)
    |-> (wr_data_o == 8'(w_r - opnd_r - {7'h00, !status_r[`RSS_ST_C]})))
    else $error("subtract with borrow wrong");
  a_literal_sub: assert property (
    (phase_r == RSS_PH_Q4) && (op_r == RSS_OP_SUBLIT)
    |=> (w_o == 8'($past(lit_r) - $past(w_r))))
    else $error("literal subtract wrong");
  a_carry_borrow: assert property (
    (phase_r == RSS_PH_Q4) && (op_r == RSS_OP_SUBF)
    |=> (status_o[`RSS_ST_C] == ($past(opnd_r) >= $past(w_r))))
    else $error("carry not inverted borrow");

endmodule // rss_exec

// ---- common/rss_defines.svh ----
// Purpose: Opcode patterns, field positions, reset values for the subtract/rotate/sleep unit
// Assumes: 16-bit instruction words, 8-bit data path
// Notes:   Included by the execution unit and its arithmetic slice
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// Opcode masks and match values
`define RSS_RRNC_MASK    16'hfc00
`define RSS_RRNC_VAL     16'h4000
`define RSS_FILL_MASK    16'hfe00
`define RSS_FILL_VAL     16'h6800
`define RSS_SLEEP_MASK   16'hffff
`define RSS_SLEEP_VAL    16'h0003
`define RSS_SUBB_MASK    16'hfc00
`define RSS_SUBB_VAL     16'h5400
`define RSS_SUBLIT_MASK  16'hff00
`define RSS_SUBLIT_VAL   16'h0800
`define RSS_SUBF_MASK    16'hfc00
`define RSS_SUBF_VAL     16'h5c00

// Instruction field positions
`define RSS_BIT_D        9
`define RSS_BIT_A        8

// Data constants
`define RSS_ALL_ONES     8'hff
`define RSS_ILO_MAX      8'h5f
`define RSS_ACC_LO_BANK  4'h0
`define RSS_ACC_HI_BANK  4'hf

// Status bit positions
`define RSS_ST_C         0
`define RSS_ST_DC        1
`define RSS_ST_Z         2
`define RSS_ST_OV        3
`define RSS_ST_N         4

// Reset values
`define RSS_STATUS_RST   5'h00
`define RSS_W_RST        8'h00
`define RSS_TMO_RST      1'b1
`define RSS_PWD_RST      1'b1

`endif

// ---- common/rss_pkg.sv ----
// Purpose: Types shared by the subtract/rotate/sleep unit
// Assumes: Nothing beyond the defines header
// Notes:   Phase order follows the four-phase instruction cycle
package rss_pkg;

  typedef enum logic [2:0] {
    RSS_OP_NONE,
    RSS_OP_RRNC,
    RSS_OP_FILL,
    RSS_OP_SLEEP,
    RSS_OP_SUBB,
    RSS_OP_SUBLIT,
    RSS_OP_SUBF
  } rss_op_t;

  typedef enum logic [2:0] {
    RSS_PH_Q1,
    RSS_PH_Q2,
    RSS_PH_Q3,
    RSS_PH_Q4,
    RSS_PH_SLEEP
  } rss_phase_t;

endpackage

// ---- logic/rss_alu.sv ----
// Purpose: Result and flag computation for rotate, fill and subtract operations
// Assumes: Operands are stable for the whole process phase
// Notes:   Purely combinational; the caller latches the outputs
`timescale 1ns/1ps
`include "rss_defines.svh"

module rss_alu
  import rss_pkg::*;
(
  // Operation and operands
  input  wire rss_pkg::rss_op_t op_i,
  input  wire logic [7:0]       file_val_i,
  input  wire logic [7:0]       w_val_i,
  input  wire logic [7:0]       lit_i,
  input  wire logic             carry_i,
  // Result and flags
  output logic      [7:0]       result_o,
  output logic                  n_o,
  output logic                  ov_o,
  output logic                  z_o,
  output logic                  dc_o,
  output logic                  c_o
);

  logic [7:0] a_v;
  logic [7:0] b_v;
  logic       cin_v;
  logic [8:0] sum_v;
  logic [4:0] nib_v;

  // Subtraction as a + ~b + cin, so carry out is the inverted borrow
  always_comb
  begin
    a_v   = file_val_i;
    b_v   = w_val_i;
    cin_v = 1'b1;
    case (op_i)
      RSS_OP_SUBLIT:
      begin
        a_v = lit_i;
      end
      RSS_OP_SUBB:
      begin
        a_v   = w_val_i;
        b_v   = file_val_i;
        cin_v = carry_i;
      end
      default:
      begin
        a_v = file_val_i;
      end
    endcase
    sum_v = {1'b0, a_v} + {1'b0, ~b_v} + {8'h00, cin_v};
    nib_v = {1'b0, a_v[3:0]} + {1'b0, ~b_v[3:0]} + {4'h0, cin_v};
    case (op_i)
      RSS_OP_RRNC:   result_o = {file_val_i[0], file_val_i[7:1]};
      RSS_OP_FILL:   result_o = `RSS_ALL_ONES;
      default:       result_o = sum_v[7:0];
    endcase
    n_o  = result_o[7];
    z_o  = (result_o == 8'h00);
    c_o  = sum_v[8];
    dc_o = nib_v[4];
    ov_o = (a_v[7] != b_v[7]) && (sum_v[7] != a_v[7]);
  end

endmodule // rss_alu

// ---- test/rss_exec_bench.sv ----
// Purpose: Self-checking bench for the rotate, fill, sleep and subtract unit
// Assumes: Register file modelled here, read data combinational on rd_addr_o
// Notes:   Each instruction is held until taken, then judged at Q2, Q4 and after
`timescale 1ns/1ps
module rss_exec_bench;
  import rss_pkg::*;
  logic        mclk_i;
  logic        sys_rst_i;
  logic [15:0] instr_i;
  logic        instr_valid_i;
  logic        instr_take_o;
  logic [3:0]  bank_select_reg_i;
  logic        ext_set_en_i;
  logic [11:0] fsr2_i;
  logic [11:0] rd_addr_o;
  logic        rd_en_o;
  wire  [7:0]  rd_data_i;
  logic [11:0] wr_addr_o;
  logic        wr_en_o;
  logic [7:0]  wr_data_o;
  logic [7:0]  w_o;
  logic [4:0]  status_o;
  logic        timeout_flag_o;
  logic        powerdown_flag_o;
  logic        sleep_o;
  logic        watchdog_clr_o;
  logic        wake_i;
  logic        watchdog_wake_i;
  logic [7:0]  mem [0:4095];
  logic [7:0]  w_e;
  logic [4:0]  st_e;
  logic [12:0] ref_v;
  logic        rd_s;
  logic        wr_s;
  logic        clr_s;
  logic [11:0] ra_s;
  logic [11:0] wa_s;
  logic [7:0]  wd_s;
  int          err_count;
  int          n_tests;

  rss_exec #(.BANK_W(4)) dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .instr_take_o(instr_take_o),
    .bank_select_reg_i(bank_select_reg_i), .ext_set_en_i(ext_set_en_i), .fsr2_i(fsr2_i),
    .rd_addr_o(rd_addr_o), .rd_en_o(rd_en_o), .rd_data_i(rd_data_i),
    .wr_addr_o(wr_addr_o), .wr_en_o(wr_en_o), .wr_data_o(wr_data_o),
    .w_o(w_o), .status_o(status_o),
    .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
    .sleep_o(sleep_o), .watchdog_clr_o(watchdog_clr_o), .wake_i(wake_i),
    .watchdog_wake_i(watchdog_wake_i)
  );

  assign rd_data_i = mem[rd_addr_o];

  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
    if (wr_en_o === 1'b1)
      mem[wr_addr_o] <= wr_data_o;

  task automatic chk_v(input logic [11:0] got, input logic [11:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d mismatches, %0d comparisons", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Flags {N,OV,Z,DC,C} and result of a - b - borrow, carry meaning no borrow
  function automatic logic [12:0] sub_ref(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
    return {r[7], (a[7] != b[7]) && (r[7] != a[7]), r[7:0] == 8'h00, ~h[4], ~r[8], r[7:0]};
  endfunction

  // Hold the word until taken, sample Q2, Q4 and the cycle after
  task automatic run(input logic [15:0] ins);
    int k;
    @(posedge mclk_i);
    instr_i <= ins;
    instr_valid_i <= 1'b1;
    k = 0;
    @(negedge mclk_i);
    while (instr_take_o !== 1'b1 && k < 8)
    begin
      @(negedge mclk_i);
      k++;
    end
    if (k >= 8)
    begin
      chk_b(1'b0, 1'b1, "take wait");
      give_verdict();
    end
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    @(negedge mclk_i);
    rd_s = rd_en_o;
    ra_s = rd_addr_o;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    wr_s = wr_en_o;
    wa_s = wr_addr_o;
    wd_s = wr_data_o;
    @(negedge mclk_i);
    clr_s = watchdog_clr_o;
  endtask

  task automatic chk_core();
    chk_v(w_o, w_e, "w");
    chk_v(status_o, st_e, "status");
  endtask

  task automatic t_reset();
    @(negedge mclk_i);
    chk_core();
    chk_b(timeout_flag_o, 1'b1, "to rst");
    chk_b(powerdown_flag_o, 1'b1, "powerdown rst");
    chk_b(sleep_o, 1'b0, "sleep rst");
    chk_b(instr_take_o, 1'b1, "take rst");
  endtask

  task automatic t_rotate();
    mem[12'hf60] = 8'hd7;
    run(16'h4260);
    st_e = {1'b1, st_e[3], 1'b0, st_e[1:0]};
    chk_b(rd_s, 1'b1, "rd en");
    chk_v(wa_s, 12'hf60, "rot addr");
    chk_b(wr_s, 1'b1, "rot wr");
    chk_v(wd_s, 12'h0eb, "rot data");
    chk_core();
    @(posedge mclk_i);
    bank_select_reg_i <= 4'h3;
    ext_set_en_i <= 1'b1;
    mem[12'h310] = 8'h01;
    run(16'h4110);
    w_e = 8'h80;
    chk_v(ra_s, 12'h310, "bank addr");
    chk_b(wr_s, 1'b0, "rot to w");
    chk_core();
  endtask

  task automatic t_fill();
    @(posedge mclk_i);
    fsr2_i <= 12'h200;
    mem[12'h205] = 8'h5a;
    run(16'h6805);
    chk_v(wa_s, 12'h205, "fill addr");
    chk_b(wr_s, 1'b1, "fill wr");
    chk_v(wd_s, 12'h0ff, "fill data");
    chk_core();
  endtask

  task automatic t_sub_w_from_literal_op();
    logic [7:0] ks [3];
    ks = '{8'h02, 8'h82, 8'h81};
    foreach (ks[i])
    begin
      ref_v = sub_ref(ks[i], w_e, 1'b1);
      run({8'h08, ks[i]});
      {st_e, w_e} = ref_v;
      chk_b(wr_s, 1'b0, "sub_w_from_literal_op wr");
      chk_core();
    end
  endtask

  task automatic t_sub_w_from_file_op();
    mem[12'hf80] = 8'h03;
    ref_v = sub_ref(8'h03, w_e, 1'b1);
    run(16'h5e80);
    st_e = ref_v[12:8];
    chk_v(wa_s, 12'hf80, "sub_w_from_file_op addr");
    chk_v(wd_s, {4'h0, ref_v[7:0]}, "sub_w_from_file_op data");
    chk_core();
    mem[12'h25f] = w_e;
    run(16'h5c5f);
    w_e = 8'h00;
    st_e = 5'h07;
    chk_v(ra_s, 12'h25f, "ilo edge");
    chk_b(wr_s, 1'b0, "sub_w_from_file_op to w");
    chk_core();
  endtask

  task automatic t_sub_f_from_w_borrow_op();
    ref_v = sub_ref(w_e, 8'heb, st_e[0]);
    run(16'h5660);
    st_e = ref_v[12:8];
    chk_v(wd_s, {4'h0, ref_v[7:0]}, "fwb data");
    chk_core();
    ref_v = sub_ref(w_e, ref_v[7:0], st_e[0]);
    run(16'h5460);
    {st_e, w_e} = ref_v;
    chk_b(wr_s, 1'b0, "fwb to w");
    chk_core();
  endtask

  task automatic t_sleep();
    for (int i = 0; i < 2; i++)
    begin
      run(16'h0003);
      chk_b(clr_s, 1'b1, "watchdog clr");
      chk_b(sleep_o, 1'b1, "asleep");
      chk_b(instr_take_o, 1'b0, "no take");
      chk_b(timeout_flag_o, 1'b1, "to set");
      chk_b(powerdown_flag_o, 1'b0, "powerdown clr");
      @(posedge mclk_i);
      instr_i <= 16'h0801;
      instr_valid_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      watchdog_wake_i <= (i == 0);
      wake_i <= (i == 1);
      @(posedge mclk_i);
      watchdog_wake_i <= 1'b0;
      wake_i <= 1'b0;
      instr_valid_i <= 1'b0;
      @(negedge mclk_i);
      chk_b(sleep_o, 1'b0, "woke");
      chk_b(timeout_flag_o, i == 1, "to wake");
      chk_core();
    end
  endtask

  initial
  begin
    err_count = 0;
    n_tests = 0;
    sys_rst_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    bank_select_reg_i = 4'h0;
    ext_set_en_i = 1'b0;
    fsr2_i = 12'h000;
    wake_i = 1'b0;
    watchdog_wake_i = 1'b0;
    w_e = 8'h00;
    st_e = 5'h00;
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'h00;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_rotate();
    t_fill();
    t_sub_w_from_literal_op();
    t_sub_w_from_file_op();
    t_sub_f_from_w_borrow_op();
    t_sleep();
    give_verdict();
  end
endmodule // rss_exec_bench
